// [logic/byte_mask_zero_unit.sv]
`timescale 1ns/100ps
module byte_mask_zero_unit
    import byte_mask_pkg::*;
#(
    // datapath shape
    parameter int DATA_W = DATA_WIDTH,
    parameter int LANES  = BYTE_COUNT,
    parameter int IDX_W  = START_IDX_BITS,
    parameter int MASK_W = WIDE_MASK_BITS,
    parameter int DEST_W = 5
)
(
    // clock, reset, enable
    input  wire logic            i_mclk,
    input  wire logic            i_rst,
    input  wire logic            i_ce,
    // issue from pipeline
    input  wire logic            i_issue_valid,
    input  wire byte_op_type     i_op,
    input  wire field_width_type i_width,
    input  wire logic [63:0]     i_src_a_reg,
    input  wire logic [63:0]     i_src_b_operand,
    input  wire logic            i_use_literal,
    input  wire logic [7:0]      i_literal,
    input  wire logic [4:0]      i_dest_reg,
    // result to register file
    output logic                 o_result_valid,
    output logic [4:0]           o_dest_reg,
    output logic [63:0]          o_result
);

    // ==========================================================
    // elaboration checks on the datapath shape
    // the ports are fixed at a quadword with eight byte lanes, so
    // any other shape would silently cut or pad the operands
    if (DATA_W != DATA_WIDTH) begin : g_bad_data_w
        $error("byte_mask_zero_unit: data width must stay a quadword");
    end
    if (LANES * 8 != DATA_W) begin : g_bad_lanes
        $error("byte_mask_zero_unit: lane count must match data width");
    end
    if ((1 << IDX_W) != LANES) begin : g_bad_idx_w
        $error("byte_mask_zero_unit: start index must address every lane");
    end
    if (MASK_W != 2 * LANES) begin : g_bad_mask_w
        $error("byte_mask_zero_unit: wide mask must cover two registers");
    end
    if (DEST_W != 5) begin : g_bad_dest_w
        $error("byte_mask_zero_unit: destination number is five bits");
    end

    // ==========================================================
    // internal signals
    // second operand after the literal choice
    logic [DATA_W-1:0] lit_ext;
    logic [DATA_W-1:0] src_b;
    logic [IDX_W-1:0]  start_idx;
    logic [LANES-1:0]  sel_bits;
    // field mask before and after the shift
    logic [MASK_W-1:0] base_mask;
    logic [MASK_W-1:0] wide_mask;
    // decoded operation
    logic              mask_low_sel;
    logic              mask_high_sel;
    logic              clr_ones_sel;
    logic              clr_zeros_sel;
    // per-lane clear and its result
    logic [LANES-1:0]  clear_sel;
    logic [DATA_W-1:0] result_d;
    logic [DATA_W-1:0] result_q;
    // handshake and destination
    logic              valid_d;
    logic              valid_q;
    logic [DEST_W-1:0] dest_d;
    logic [DEST_W-1:0] dest_q;

    // shared carrier between this unit and the lane clear
    byte_clear_if clr ();

    // ==========================================================
    // operand select
    // literal is zero-extended so its high lanes never select anything
    assign lit_ext = {{(DATA_W-8){1'b0}}, i_literal};
    assign src_b   = i_use_literal ? lit_ext : i_src_b_operand;

    // start lane and per-lane select taken from the chosen operand
    assign start_idx = src_b[IDX_W-1:0];
    assign sel_bits  = src_b[LANES-1:0];

    // ==========================================================
    // field width from the function code
    always_comb begin
        case (i_width)
            width_byte: base_mask = FIELD_BYTE_MASK;
            width_word: base_mask = FIELD_WORD_MASK;
            width_long: base_mask = FIELD_LONG_MASK;
            default:    base_mask = FIELD_QUAD_MASK;
        endcase
    end

    // shift by start byte index; the top half holds the overflow lanes
    assign wide_mask = base_mask << start_idx;

    // ==========================================================
    // operation decode
    // one select per family keeps the clear chain free of op codes
    always_comb begin
        mask_low_sel  = 1'b0;
        mask_high_sel = 1'b0;
        clr_ones_sel  = 1'b0;
        clr_zeros_sel = 1'b0;
        case (i_op)
            mask_field_low_op: begin
                mask_low_sel = 1'b1;
            end
            mask_field_high_op: begin
                mask_high_sel = 1'b1;
            end
            clear_selected_bytes_op: begin
                clr_ones_sel = 1'b1;
            end
            clear_unselected_bytes_op: begin
                clr_zeros_sel = 1'b1;
            end
            default: begin
                mask_low_sel = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // clear select per operation
    // low half for the low variant, top half for the high variant
    always_comb begin
        if (mask_low_sel) begin
            clear_sel = wide_mask[LANES-1:0];
        end else if (mask_high_sel) begin
            clear_sel = wide_mask[MASK_W-1:LANES];
        end else if (clr_ones_sel) begin
            clear_sel = sel_bits;
        end else if (clr_zeros_sel) begin
            clear_sel = ~sel_bits;
        end else begin
            clear_sel = '0;                        // pass leaves every lane
        end
    end

    // ==========================================================
    // byte clear datapath
    // the source goes through untouched except for selected lanes
    assign clr.data      = i_src_a_reg;
    assign clr.clear_sel = clear_sel;

    byte_clear_function u_clear (
        .bus (clr.unit)
    );

    assign result_d = clr.result;

    // ==========================================================
    // result register
    // reset sits inside the enable so a frozen pipeline keeps all state
    always_ff @(posedge i_mclk) begin
        if (i_ce) begin
            if (i_rst) begin
                result_q <= RESULT_RESET;
            end else if (i_issue_valid) begin
                result_q <= result_d;
            end
        end
    end

    // valid pulse, one per accepted op
    assign valid_d = i_issue_valid;

    always_ff @(posedge i_mclk) begin
        if (i_ce) begin
            if (i_rst) begin
                valid_q <= 1'b0;
            end else begin
                valid_q <= valid_d;
            end
        end
    end

    // destination number, meaningful only beside the valid pulse
    assign dest_d = i_dest_reg;

    always_ff @(posedge i_mclk) begin
        if (i_ce) begin
            if (i_rst) begin
                dest_q <= DEST_RESET;
            end else begin
                dest_q <= dest_d;
            end
        end
    end

    // ==========================================================
    // outputs straight from the flip-flops
    // no exception output: none of these ops can fault
    assign o_result_valid = valid_q;
    assign o_dest_reg     = dest_q;
    assign o_result       = result_q;

endmodule

// [common/byte_mask_pkg.sv]
package byte_mask_pkg;

    // ==========================================================
    // datapath widths
    localparam int DATA_WIDTH     = 64;
    localparam int BYTE_COUNT     = 8;
    localparam int START_IDX_BITS = 3;
    localparam int WIDE_MASK_BITS = 16;

    // ==========================================================
    // field widths as byte masks before the shift
    localparam logic [15:0] FIELD_BYTE_MASK = 16'h0001;
    localparam logic [15:0] FIELD_WORD_MASK = 16'h0003;
    localparam logic [15:0] FIELD_LONG_MASK = 16'h000F;
    localparam logic [15:0] FIELD_QUAD_MASK = 16'h00FF;

    // ==========================================================
    // reset values of the result registers
    localparam logic [63:0] RESULT_RESET    = 64'h0000000000000000;
    localparam logic [4:0]  DEST_RESET      = 5'h00;

    // ==========================================================
    // operation codes issued by the pipeline
    typedef enum logic [2:0] {
        mask_field_low_op,
        mask_field_high_op,
        clear_selected_bytes_op,
        clear_unselected_bytes_op,
        pass_op
    } byte_op_type;

    // field width picked by the function code
    typedef enum logic [1:0] {
        width_byte,
        width_word,
        width_long,
        width_quad
    } field_width_type;

endpackage

// [common/byte_clear_if.sv]
`timescale 1ns/100ps
interface byte_clear_if;
    import byte_mask_pkg::*;
    logic [63:0] data;
    logic [7:0]  clear_sel;
    logic [63:0] result;
    modport src (output data, output clear_sel, input result);
    modport unit (input data, input clear_sel, output result);
endinterface

// [logic/byte_clear_function.sv]
`timescale 1ns/100ps
module byte_clear_function
    import byte_mask_pkg::*;
(
    // operands and result
    byte_clear_if.unit bus
);

    // ==========================================================
    // per-byte clear
    for (genvar i = 0; i < BYTE_COUNT; i++) begin : g_byte
        // select bit i governs byte i
        assign bus.result[8*i +: 8] = bus.clear_sel[i] ? 8'h00 : bus.data[8*i +: 8];
    end

endmodule

// [verif/bmz_props.sv]
`timescale 1ns/100ps
module bmz_props
    import byte_mask_pkg::*;
(
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic        i_ce,
    input wire logic        i_issue_valid,
    input wire byte_op_type i_op,
    input wire logic [63:0] i_src_a_reg,
    input wire logic [63:0] i_src_b_operand,
    input wire logic        i_use_literal,
    input wire logic [4:0]  i_dest_reg,
    input wire logic        o_result_valid,
    input wire logic [4:0]  o_dest_reg,
    input wire logic [63:0] o_result
);
    op_taken_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_ce && i_issue_valid |=> o_result_valid) else $error("pulse missing");
    pulse_end_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_ce && !i_issue_valid |=> !o_result_valid) else $error("pulse too long");
    reset_clear_a: assert property (@(posedge i_mclk)
        i_rst && i_ce |=> !o_result_valid && o_result == 64'h0 && o_dest_reg == 5'h00)
        else $error("reset left state");
    freeze_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        !i_ce |=> $stable(o_result) && $stable(o_result_valid) && $stable(o_dest_reg))
        else $error("state moved while frozen");
    dest_follow_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_ce && i_issue_valid |=> o_dest_reg == $past(i_dest_reg))
        else $error("destination wrong");
    src_subset_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_ce && i_issue_valid |=> (o_result & ~$past(i_src_a_reg)) == 64'h0)
        else $error("result bit not from source");
    pass_through_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_ce && i_issue_valid && i_op == pass_op |=> o_result == $past(i_src_a_reg))
        else $error("pass op changed data");
    sel_clear_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_ce && i_issue_valid && i_op == clear_selected_bytes_op && !i_use_literal
        && i_src_b_operand[0] |=> o_result[7:0] == 8'h00)
        else $error("selected byte kept");
    unsel_clear_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_ce && i_issue_valid && i_op == clear_unselected_bytes_op && !i_use_literal
        && !i_src_b_operand[1] |=> o_result[15:8] == 8'h00)
        else $error("unselected byte kept");
endmodule
bind byte_mask_zero_unit bmz_props props (
    .i_mclk          (i_mclk),
    .i_rst           (i_rst),
    .i_ce            (i_ce),
    .i_issue_valid   (i_issue_valid),
    .i_op            (i_op),
    .i_src_a_reg     (i_src_a_reg),
    .i_src_b_operand (i_src_b_operand),
    .i_use_literal   (i_use_literal),
    .i_dest_reg      (i_dest_reg),
    .o_result_valid  (o_result_valid),
    .o_dest_reg      (o_dest_reg),
    .o_result        (o_result)
);

// [verif/regfile_model.sv]
`timescale 1ns/100ps
module regfile_model (
    input wire logic        i_mclk,
    input wire logic        i_wr,
    input wire logic [4:0]  i_idx,
    input wire logic [63:0] i_data
);
    logic [63:0] rf [32];
    // result write-back
    always @(posedge i_mclk) if (i_wr) rf[i_idx] <= i_data;
endmodule

// [verif/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    import byte_mask_pkg::*;
    logic            i_mclk          = 1'b0;
    logic            i_rst           = 1'b1;
    logic            i_ce            = 1'b1;
    logic            i_issue_valid   = 1'b0;
    byte_op_type     i_op            = pass_op;
    field_width_type i_width         = width_byte;
    logic [63:0]     i_src_a_reg     = 64'h8877665544332211;
    logic [63:0]     i_src_b_operand = 64'h0;
    logic            i_use_literal   = 1'b0;
    logic [7:0]      i_literal       = 8'h00;
    logic [4:0]      i_dest_reg      = 5'h00;
    logic            o_result_valid;
    logic [4:0]      o_dest_reg;
    logic [63:0]     o_result;
    int              miscompares     = 0;
    int              check_count     = 0;
    int              cyc             = 0;
    // rows: op, width, operand low byte, expected result
    localparam int   ROWS = 9;
    byte_op_type     ro [ROWS] = '{mask_field_low_op, mask_field_high_op,
        clear_selected_bytes_op, clear_unselected_bytes_op, mask_field_low_op,
        mask_field_high_op, mask_field_low_op, mask_field_high_op, pass_op};
    field_width_type rw [ROWS] = '{width_byte, width_word, width_byte, width_byte,
        width_long, width_quad, width_quad, width_quad, width_byte};
    logic [7:0]      rb [ROWS] = '{8'h05, 8'h07, 8'h81, 8'h81, 8'h06, 8'h03, 8'h00,
        8'h00, 8'hFF};
    logic [63:0]     re [ROWS] = '{64'h8877005544332211, 64'h8877665544332200,
        64'h0077665544332200, 64'h8800000000000011, 64'h0000665544332211,
        64'h8877665544000000, 64'h0000000000000000, 64'h8877665544332211,
        64'h8877665544332211};
    byte_mask_zero_unit dut (
        .i_mclk          (i_mclk),
        .i_rst           (i_rst),
        .i_ce            (i_ce),
        .i_issue_valid   (i_issue_valid),
        .i_op            (i_op),
        .i_width         (i_width),
        .i_src_a_reg     (i_src_a_reg),
        .i_src_b_operand (i_src_b_operand),
        .i_use_literal   (i_use_literal),
        .i_literal       (i_literal),
        .i_dest_reg      (i_dest_reg),
        .o_result_valid  (o_result_valid),
        .o_dest_reg      (o_dest_reg),
        .o_result        (o_result)
    );
    regfile_model pm (
        .i_mclk (i_mclk),
        .i_wr   (o_result_valid),
        .i_idx  (o_dest_reg),
        .i_data (o_result)
    );
    // clock and hang guard
    always #50 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (++cyc > 300) begin
        miscompares++;
        complete_run;
    end
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic iss(input byte_op_type op, input field_width_type w,
                       input logic [7:0] b, input logic [4:0] d);
        @(posedge i_mclk) #1;
        i_op            = op;
        i_width         = w;
        i_src_b_operand = {{56{1'b1}}, b};
        i_dest_reg      = d;
        i_issue_valid   = 1'b1;
        @(posedge i_mclk) #1;
        i_issue_valid   = 1'b0;
    endtask
    task complete_run;
        $display("checks %0d bad %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge i_mclk);
        #1 i_rst = 1'b0;
        chk(o_result, 64'h0);
        chk(64'(o_result_valid), 64'h0);
        $display("reset test done");
        for (int k = 0; k < ROWS; k++) begin
            iss(ro[k], rw[k], rb[k], 5'(k));
            chk(o_result, re[k]);
            chk(64'(o_dest_reg), 64'(k));
            chk(64'(o_result_valid), 64'h1);
            $display("row %0d done", k);
        end
        @(posedge i_mclk) #1;
        chk(pm.rf[8], re[8]);
        chk(64'(o_result_valid), 64'h0);
        $display("write-back test done");
        i_use_literal = 1'b1;
        i_literal     = 8'h0F;
        iss(clear_selected_bytes_op, width_byte, 8'hFF, 5'h09);
        chk(o_result, 64'h8877665500000000);
        i_use_literal = 1'b0;
        $display("literal test done");
        i_ce = 1'b0;
        iss(clear_selected_bytes_op, width_byte, 8'hFF, 5'h02);
        chk(o_result, 64'h8877665500000000);
        chk(64'(o_dest_reg), 64'h9);
        $display("freeze test done");
        i_ce  = 1'b1;
        i_rst = 1'b1;
        @(posedge i_mclk) #1;
        chk(o_result, 64'h0);
        chk(64'(o_result_valid), 64'h0);
        chk(64'(o_dest_reg), 64'h0);
        i_rst = 1'b0;
        iss(ro[0], rw[0], rb[0], 5'h01);
        chk(o_result, re[0]);
        $display("mid-run reset test done");
        complete_run;
    end
endmodule
